// file: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import wdog_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] last_rd;
  logic last_err;

  // The bus is idle from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer, held until pready is seen high at a rising edge.
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~data;
  endtask

  // Sends the four expected bytes of a question, byte 3 first.
  task automatic answer(input logic [3:0] q, input logic sync);
    logic [31:0] bytes;
    bytes = ANSWER_TABLE[q];
    for (int i = 3; i >= 0; i--) begin
      xfer(1'b1, sync ? OFS_ANSWER_SYNC : OFS_ANSWER, {24'h00_0000, bytes[i*8 +: 8]});
    end
  endtask
endmodule
`default_nettype wire

// file: sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
module sat_counter
  import wdog_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Step requests and value.
  sat_if.counter port
);
  typedef struct packed {
    logic [5:0] value;
  } cnt_t;

  cnt_t st_ff;
  cnt_t nxt_st;
  logic [6:0] sum;

  // Increment first, then decrement; a step past either end is dropped.
  always_comb begin
    nxt_st = st_ff;
    sum = {1'b0, st_ff.value} + {3'h0, port.up};
    if (port.inc && !sum[6]) begin
      nxt_st.value = sum[5:0];
    end
    if (port.dec && nxt_st.value >= {2'h0, port.dn}) begin
      nxt_st.value = nxt_st.value - {2'h0, port.dn};
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port.value = st_ff.value;
endmodule
`default_nettype wire

// file: sat_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sat_if;
  logic inc;
  logic dec;
  logic [3:0] up;
  logic [3:0] dn;
  logic [5:0] value;
  modport counter(input inc, input dec, input up, input dn, output value);
  modport user(output inc, output dec, output up, output dn, input value);
endinterface
`default_nettype wire

// file: wdog_monitor.sv
// Behaviour
// - Open-window service lowers, failure raises error count.
// - Window error counter is six bits.
// - Timing register write raises count, restarts sequence.
// - Sequence is closed window then open window.
// - Reset release, service, timing write, overflow restart.
// - Sequence loops forever except reset or halt.
// - Timing loads from register or service data.
// - Early or missing service sets sticky flags.
// - Service flag set on service, cleared read/timeout.
// - Pass lowers pass counter; failure only reported.
// - Functional error on any bad answer byte or sync.
// - Current and previous answer error flags held.
// - Heartbeat events raise the pass counter.
// - Zero period data leaves period unchanged.
// - Sync clears index and timer, fires, defers period.
// - Period write acts now, may fire immediately.
// - Pass counter six bits, steps from register.
// - Hold-question reuses question after window error.
// - Four-bit question, bytes 3..0 by index.
// - Next question from two selectable patterns.
// - Each question has four fixed expected bytes.
// - Counters drop a step that would pass either end.
`timescale 1ns/1ps
`default_nettype none
module wdog_monitor
  import wdog_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Abnormal operating condition from the supply logic.
  input wire logic monitor_halt,
  // Event pulses to the total error logic.
  output logic window_error_pulse,
  output logic functional_error_pulse,
  output logic heartbeat_pulse
);
  typedef struct packed {
    win_state_t win;
    logic [10:0] win_pre;
    logic [7:0] win_ticks;
    logic [7:0] closed_t;
    logic [7:0] open_t;
    logic [7:0] win_step;
    logic too_early;
    logic timeout;
    logic svc_rcv;
    logic [10:0] hb_pre;
    logic [6:0] hb_ticks;
    logic [6:0] hb_period;
    logic [6:0] hb_pend;
    logic hb_pend_v;
    logic [7:0] pass_step;
    logic hold_q;
    logic q_mode;
    logic [1:0] idx;
    logic bad;
    logic [3:0] question_code;
    logic [7:0] seq;
    logic cur_err;
    logic prev_err;
    logic [31:0] rdata;
    logic win_err_p;
    logic fwd_err_p;
    logic hb_p;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  sat_if w_if();
  sat_if p_if();
  logic wr, rd, hit, restart, win_tick, win_end, hb_tick, hb_end, hb_event;
  logic svc_wr, ans_wr, byte_bad, nbad, pass_now, hold_now;
  logic [8:0] win_limit;
  logic [7:0] exp_byte;
  logic [1:0] sel;
  logic [7:0] nseq;

  // Window error counter and pass counter share one saturating design.
  sat_counter u_win_cnt (.clk(pclk), .rst_n(presetn), .port(w_if.counter));
  sat_counter u_pass_cnt (.clk(pclk), .rst_n(presetn), .port(p_if.counter));
  assign w_if.up = st_ff.win_step[3:0];
  assign w_if.dn = st_ff.win_step[7:4];
  assign p_if.up = st_ff.pass_step[3:0];
  assign p_if.dn = st_ff.pass_step[7:4];

  // Bus phase decode; the slave answers in the first access cycle.
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign svc_wr = wr && paddr == OFS_WIN_SERVICE;
  assign ans_wr = wr && (paddr == OFS_ANSWER || paddr == OFS_ANSWER_SYNC);
  assign pready = psel && penable;
  assign pslverr = pready && !hit;
  assign prdata = st_ff.rdata;
  assign window_error_pulse = st_ff.win_err_p;
  assign functional_error_pulse = st_ff.fwd_err_p;
  assign heartbeat_pulse = st_ff.hb_p;

  // Address decode.
  always_comb begin
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr <= OFS_QUESTION_CODE_STAT) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Window timer, service check and sticky diagnosis.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.win_err_p = 1'b0;
    nxt_st.fwd_err_p = 1'b0;
    nxt_st.hb_p = 1'b0;
    restart = 1'b0;
    w_if.inc = 1'b0;
    w_if.dec = 1'b0;
    win_tick = st_ff.win_pre == UNIT_LAST;
    nxt_st.win_pre = win_tick ? 11'h000 : st_ff.win_pre + 11'h001;
    if (win_tick) begin
      nxt_st.win_ticks = st_ff.win_ticks + 8'h01;
    end
    win_limit = {1'b0, (st_ff.win == WIN_CLOSED) ? st_ff.closed_t : st_ff.open_t};
    win_end = win_tick && ({1'b0, st_ff.win_ticks} + 9'h001 >= win_limit);
    if (win_end && st_ff.win == WIN_CLOSED) begin
      nxt_st.win = WIN_OPEN;
      nxt_st.win_ticks = 8'h00;
    end else if (win_end && !svc_wr) begin
      nxt_st.timeout = 1'b1;
      nxt_st.too_early = 1'b0;
      nxt_st.svc_rcv = 1'b0;
      nxt_st.win_err_p = 1'b1;
      w_if.inc = 1'b1;
      restart = 1'b1;
    end
    if (rd && paddr == OFS_STATUS0) begin
      nxt_st.svc_rcv = 1'b0;
    end
    if (svc_wr) begin
      if (pwdata[15:0] != 16'h0000) begin
        nxt_st.closed_t = pwdata[7:0];
        nxt_st.open_t = pwdata[OPEN_LSB +: 8];
      end
      if (st_ff.win == WIN_OPEN) begin
        w_if.dec = 1'b1;
        nxt_st.too_early = 1'b0;
        nxt_st.timeout = 1'b0;
      end else begin
        w_if.inc = 1'b1;
        nxt_st.win_err_p = 1'b1;
        nxt_st.too_early = 1'b1;
        nxt_st.timeout = 1'b0;
      end
      nxt_st.svc_rcv = 1'b1;
      restart = 1'b1;
    end
    if (wr && paddr == OFS_WIN_TIMING) begin
      nxt_st.closed_t = pwdata[7:0];
      nxt_st.open_t = pwdata[OPEN_LSB +: 8];
      w_if.inc = 1'b1;
      restart = 1'b1;
    end
    if (restart || monitor_halt) begin
      nxt_st.win = WIN_CLOSED;
      nxt_st.win_pre = 11'h000;
      nxt_st.win_ticks = 8'h00;
    end

    // Heartbeat timer.
    hb_event = 1'b0;
    hb_tick = st_ff.hb_pre == UNIT_LAST;
    nxt_st.hb_pre = hb_tick ? 11'h000 : st_ff.hb_pre + 11'h001;
    if (hb_tick) begin
      nxt_st.hb_ticks = st_ff.hb_ticks + 7'h01;
    end
    hb_end = hb_tick && ({1'b0, st_ff.hb_ticks} + 8'h01 >= {1'b0, st_ff.hb_period});
    if (hb_end) begin
      hb_event = 1'b1;
      nxt_st.hb_ticks = 7'h00;
      if (st_ff.hb_pend_v) begin
        nxt_st.hb_period = st_ff.hb_pend;
        nxt_st.hb_pend_v = 1'b0;
      end
    end
    if (wr && paddr == OFS_HB_PERIOD && pwdata[6:0] != 7'h00) begin
      nxt_st.hb_period = pwdata[6:0];
      if (pwdata[6:0] < st_ff.hb_ticks) begin
        hb_event = 1'b1;
        nxt_st.hb_ticks = 7'h00;
        nxt_st.hb_pre = 11'h000;
      end
    end
    if (wr && paddr == OFS_HB_SYNC) begin
      if (pwdata[6:0] != 7'h00) begin
        nxt_st.hb_pend = pwdata[6:0];
        nxt_st.hb_pend_v = 1'b1;
      end
      nxt_st.idx = 2'h0;
      nxt_st.bad = 1'b0;
      nxt_st.hb_ticks = 7'h00;
      nxt_st.hb_pre = 11'h000;
      hb_event = 1'b1;
      nxt_st.fwd_err_p = 1'b1;
    end

    // Answer byte check against the lookup table.
    sel = LAST_INDEX - st_ff.idx;
    exp_byte = ANSWER_TABLE[st_ff.question_code][{sel, 3'b000} +: 8];
    byte_bad = pwdata[7:0] != exp_byte;
    nbad = st_ff.bad || byte_bad;
    pass_now = 1'b0;
    hold_now = st_ff.hold_q && (st_ff.too_early || st_ff.timeout);
    nseq = st_ff.seq + 8'h01;
    p_if.dec = 1'b0;
    if (ans_wr) begin
      if (byte_bad) begin
        nxt_st.cur_err = 1'b1;
      end
      if (st_ff.idx == LAST_INDEX) begin
        nxt_st.idx = 2'h0;
        nxt_st.bad = 1'b0;
        nxt_st.prev_err = nbad;
        if (nbad) begin
          nxt_st.fwd_err_p = 1'b1;
        end else begin
          pass_now = 1'b1;
          p_if.dec = 1'b1;
          if (!hold_now) begin
            nxt_st.seq = nseq;
            nxt_st.question_code = st_ff.q_mode ? QUESTION_ORDER[nseq[3:0] ^ nseq[7:4]]
                                        : QUESTION_ORDER[nseq[3:0]];
            nxt_st.cur_err = 1'b0;
          end
        end
        if (paddr == OFS_ANSWER_SYNC) begin
          hb_event = 1'b1;
          nxt_st.hb_ticks = 7'h00;
          nxt_st.hb_pre = 11'h000;
        end
      end else begin
        nxt_st.idx = st_ff.idx + 2'h1;
        nxt_st.bad = nbad;
      end
    end
    p_if.inc = hb_event;
    nxt_st.hb_p = hb_event;

    // Configuration writes.
    if (wr && paddr == OFS_WIN_STEP) begin
      nxt_st.win_step = pwdata[7:0];
    end
    if (wr && paddr == OFS_PASS_STEP) begin
      nxt_st.pass_step = pwdata[7:0];
    end
    if (wr && paddr == OFS_OPTION) begin
      nxt_st.hold_q = pwdata[0];
      nxt_st.q_mode = pwdata[1];
    end

    // Read data is captured in the setup cycle.
    if (psel && !penable && !pwrite) begin
      if (paddr == OFS_WIN_TIMING) begin
        nxt_st.rdata = {16'h0000, st_ff.open_t, st_ff.closed_t};
      end else if (paddr == OFS_WIN_STEP) begin
        nxt_st.rdata = {24'h00_0000, st_ff.win_step};
      end else if (paddr == OFS_HB_PERIOD) begin
        nxt_st.rdata = {25'h000_0000, st_ff.hb_period};
      end else if (paddr == OFS_PASS_STEP) begin
        nxt_st.rdata = {24'h00_0000, st_ff.pass_step};
      end else if (paddr == OFS_OPTION) begin
        nxt_st.rdata = {30'h0000_0000, st_ff.q_mode, st_ff.hold_q};
      end else if (paddr == OFS_STATUS0) begin
        nxt_st.rdata = {23'h00_0000, st_ff.svc_rcv, 2'h0, w_if.value};
      end else if (paddr == OFS_DIAG) begin
        nxt_st.rdata = {28'h000_0000, st_ff.prev_err, st_ff.cur_err,
                        st_ff.timeout, st_ff.too_early};
      end else if (paddr == OFS_PASS_STAT) begin
        nxt_st.rdata = {26'h000_0000, p_if.value};
      end else if (paddr == OFS_QUESTION_CODE_STAT) begin
        nxt_st.rdata = {26'h000_0000, st_ff.idx, st_ff.question_code};
      end else begin
        nxt_st.rdata = 32'h0000_0000;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.closed_t <= WIN_TIME_RST;
      st_ff.open_t <= WIN_TIME_RST;
      st_ff.win_step <= STEP_RST;
      st_ff.pass_step <= STEP_RST;
      st_ff.hb_period <= HB_PERIOD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Checks on the window and functional logic.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic twr;
  logic [3:0] win_up;
  assign twr = wr && paddr == OFS_WIN_TIMING;
  assign win_up = st_ff.win_step[3:0];
  property p_twr_restart;
    twr |=> st_ff.win == WIN_CLOSED && st_ff.win_ticks == 8'h00;
  endproperty
  a_twr_restart: assert property (p_twr_restart) else $error("timing write no restart");
  property p_twr_inc;
    twr && w_if.value == 6'h00 |=> w_if.value == {2'h0, $past(win_up)};
  endproperty
  a_twr_inc: assert property (p_twr_inc) else $error("timing write no increment");
  property p_early;
    svc_wr && st_ff.win == WIN_CLOSED |=> st_ff.too_early && !st_ff.timeout ##0 window_error_pulse;
  endproperty
  a_early: assert property (p_early) else $error("early service not flagged");
  property p_pass;
    svc_wr && st_ff.win == WIN_OPEN |=> !st_ff.too_early && !st_ff.timeout && st_ff.svc_rcv;
  endproperty
  a_pass: assert property (p_pass) else $error("open service not passed");
  property p_timeout;
    win_end && st_ff.win == WIN_OPEN && !svc_wr |=> st_ff.timeout && !st_ff.svc_rcv;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");
  property p_sync;
    wr && paddr == OFS_HB_SYNC |=> functional_error_pulse && heartbeat_pulse && st_ff.idx == 2'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync effects missing");
  property p_zero_period;
    wr && paddr == OFS_HB_PERIOD && pwdata[6:0] == 7'h00 && !st_ff.hb_pend_v
      |=> $stable(st_ff.hb_period);
  endproperty
  a_zero_period: assert property (p_zero_period) else $error("zero period applied");
  property p_hold;
    pass_now && hold_now |=> $stable(st_ff.question_code);
  endproperty
  a_hold: assert property (p_hold) else $error("question not held");
  property p_sat;
    p_if.value == COUNT_FULL && p_if.inc && !p_if.dec |=> p_if.value == COUNT_FULL;
  endproperty
  a_sat: assert property (p_sat) else $error("pass counter wrapped");
  c_pass: cover property (svc_wr && st_ff.win == WIN_OPEN);
  c_answer: cover property (pass_now ##1 !functional_error_pulse);
  c_timeout: cover property (win_end && st_ff.win == WIN_OPEN);
endmodule
`default_nettype wire

// file: wdog_pkg.sv
`default_nettype none
package wdog_pkg;
  // Clock and time base for window and heartbeat timing.
  localparam int PCLK_PERIOD_NS = 50;
  localparam int TIME_UNIT_NS = 100_000;
  localparam int UNIT_CYCLES = TIME_UNIT_NS / PCLK_PERIOD_NS;
  localparam logic [10:0] UNIT_LAST = 11'(UNIT_CYCLES - 1);
  // Register byte offsets.
  localparam logic [11:0] OFS_WIN_TIMING = 12'h000;
  localparam logic [11:0] OFS_WIN_STEP = 12'h004;
  localparam logic [11:0] OFS_WIN_SERVICE = 12'h008;
  localparam logic [11:0] OFS_HB_PERIOD = 12'h00c;
  localparam logic [11:0] OFS_PASS_STEP = 12'h010;
  localparam logic [11:0] OFS_OPTION = 12'h014;
  localparam logic [11:0] OFS_ANSWER = 12'h018;
  localparam logic [11:0] OFS_ANSWER_SYNC = 12'h01c;
  localparam logic [11:0] OFS_HB_SYNC = 12'h020;
  localparam logic [11:0] OFS_STATUS0 = 12'h024;
  localparam logic [11:0] OFS_DIAG = 12'h028;
  localparam logic [11:0] OFS_PASS_STAT = 12'h02c;
  localparam logic [11:0] OFS_QUESTION_CODE_STAT = 12'h030;
  // Field positions.
  localparam int OPEN_LSB = 8;
  localparam int SCR_BIT = 8;
  localparam int DN_LSB = 4;
  localparam int IDX_LSB = 4;
  // Values after reset, count limit and last answer byte index.
  localparam logic [7:0] WIN_TIME_RST = 8'h0a;
  localparam logic [7:0] STEP_RST = 8'h11;
  localparam logic [6:0] HB_PERIOD_RST = 7'h0a;
  localparam logic [5:0] COUNT_FULL = 6'h3f;
  localparam logic [1:0] LAST_INDEX = 2'h3;

  typedef enum logic {WIN_CLOSED, WIN_OPEN} win_state_t;

  // Expected answer bytes 3..0 per question code.
  localparam logic [0:15][31:0] ANSWER_TABLE = {
    32'hff0f_f000, 32'hb040_bf4f, 32'he919_e616, 32'ha656_a959,
    32'h7585_7a8a, 32'h3aca_35c5, 32'h6393_6c9c, 32'h2cdc_23d3,
    32'hd222_dd2d, 32'h9d6d_9262, 32'hc434_cb3b, 32'h8b7b_8474,
    32'h58a8_57a7, 32'h17e7_18e8, 32'h4ebe_41b1, 32'h01f1_0efe};
  // Base order of the sixteen question codes.
  localparam logic [0:15][3:0] QUESTION_ORDER = 64'h0b6d_385e_a1c7_92f4;
endpackage
`default_nettype wire

// file: window_and_question_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define RV host_model_i.last_rd
`define CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module window_and_question_watchdog_tb
  import wdog_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, monitor_halt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic window_error_pulse, functional_error_pulse, heartbeat_pulse;
  int bad_count = 0;
  int n_compared = 0;
  int hb_n = 0;
  int fe_n = 0;
  int we_n = 0;
  int hb0, fe0, we0, nsync;
  logic [3:0] wu, wd, pu, pd, q, first_q;
  logic [5:0] wcnt, pcnt;
  logic [15:0] mask;
  logic s;

  wdog_monitor wdog_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .monitor_halt(monitor_halt),
    .window_error_pulse(window_error_pulse), .functional_error_pulse(functional_error_pulse),
    .heartbeat_pulse(heartbeat_pulse));
  host_model host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Clock at 20 MHz.
  always #25 pclk = ~pclk;

  // Counts the event pulses seen at each rising edge.
  always @(posedge pclk) begin
    hb_n <= hb_n + int'(heartbeat_pulse === 1'b1);
    fe_n <= fe_n + int'(functional_error_pulse === 1'b1);
    we_n <= we_n + int'(window_error_pulse === 1'b1);
  end

  // Saturating steps: a step past either end leaves the count as it was.
  function automatic logic [5:0] inc(input logic [5:0] c, input logic [3:0] st);
    return (7'(c) + 7'(st) > 7'(COUNT_FULL)) ? c : c + 6'(st);
  endfunction
  function automatic logic [5:0] dec(input logic [5:0] c, input logic [3:0] st);
    return (st > 4'(c) && c < 6'h10) ? c : c - 6'(st);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    host_model_i.xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (45000) @(posedge pclk);
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hf448_9b23));
    presetn = 1'b0;
    monitor_halt = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_STATUS0);
    `CHECK("status0", 32'h0000_0000, `RV)
    rd(OFS_DIAG);
    `CHECK("diag", 32'h0000_0000, `RV)
    rd(OFS_QUESTION_CODE_STAT);
    `CHECK("question", 32'h0000_0000, `RV)
    rd(12'h0fc);
    `CHECK("unmapped", 1'b1, host_model_i.last_err)
    $display("test reset done");
    pu = 4'($urandom_range(15, 1));
    pd = 4'($urandom_range(15, 1));
    wr(OFS_PASS_STEP, {24'h00_0000, pd, pu});
    hb0 = hb_n;
    fe0 = fe_n;
    wr(OFS_HB_SYNC, 32'h0000_0000);
    pcnt = inc(6'h00, pu);
    repeat (2) @(posedge pclk);
    `CHECK("sync heartbeat", 1, hb_n - hb0)
    `CHECK("sync error", 1, fe_n - fe0)
    hb0 = hb_n;
    fe0 = fe_n;
    nsync = 0;
    mask = 16'h0000;
    for (int i = 0; i < 20; i++) begin
      rd(OFS_QUESTION_CODE_STAT);
      q = `RV[3:0];
      `CHECK("index", 2'h0, `RV[5:4])
      if (i == 0) first_q = q;
      if (i < 16) mask[q] = 1'b1;
      if (i == 16) begin
        `CHECK("pattern repeat", first_q, q)
        wr(OFS_OPTION, 32'h0000_0002);
      end
      s = 1'($urandom_range(1, 0));
      nsync += int'(s);
      host_model_i.answer(q, s);
      pcnt = dec(s ? inc(pcnt, pu) : pcnt, pd);
      rd(OFS_PASS_STAT);
      `CHECK("pass count", pcnt, `RV[5:0])
    end
    repeat (2) @(posedge pclk);
    `CHECK("all questions", 16'hffff, mask)
    `CHECK("answer heartbeats", nsync, hb_n - hb0)
    `CHECK("no errors", 0, fe_n - fe0)
    rd(OFS_QUESTION_CODE_STAT);
    q = `RV[3:0];
    for (int b = 0; b < 4; b++) begin
      wr(OFS_ANSWER, 32'h0000_0055);
      if (b == 0) begin
        rd(OFS_QUESTION_CODE_STAT);
        `CHECK("index step", 2'h1, `RV[5:4])
      end
    end
    repeat (2) @(posedge pclk);
    `CHECK("wrong answer", 1, fe_n - fe0)
    for (int r = 0; r < 2; r++) begin
      rd(OFS_DIAG);
      `CHECK("answer flags", 2'b11, `RV[3:2])
    end
    rd(OFS_PASS_STAT);
    `CHECK("pass kept", pcnt, `RV[5:0])
    host_model_i.answer(q, 1'b0);
    rd(OFS_DIAG);
    `CHECK("flags cleared", 2'b00, `RV[3:2])
    pcnt = dec(pcnt, pd);
    rd(OFS_PASS_STAT);
    `CHECK("pass after retry", pcnt, `RV[5:0])
    repeat (5000) @(posedge pclk);
    hb0 = hb_n;
    wr(OFS_HB_PERIOD, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    `CHECK("period now", 1, hb_n - hb0)
    repeat (2100) @(posedge pclk);
    `CHECK("new period", 2, hb_n - hb0)
    // A zero period is ignored; a synced period waits for the running one to end.
    wr(OFS_HB_PERIOD, 32'h0000_0000);
    rd(OFS_HB_PERIOD);
    `CHECK("zero period", 32'h0000_0001, `RV)
    hb0 = hb_n;
    wr(OFS_HB_SYNC, 32'h0000_0002);
    repeat (2100) @(posedge pclk);
    `CHECK("old period after sync", 2, hb_n - hb0)
    rd(OFS_HB_PERIOD);
    `CHECK("sync period", 32'h0000_0002, `RV)
    $display("test functional done");
    wu = 4'($urandom_range(15, 1));
    wd = 4'($urandom_range(15, 1));
    wr(OFS_WIN_STEP, {24'h00_0000, wd, wu});
    wr(OFS_WIN_TIMING, 32'h0000_0202);
    wcnt = inc(6'h00, wu);
    wr(OFS_WIN_SERVICE, 32'h0000_0101);
    wcnt = inc(wcnt, wu);
    rd(OFS_DIAG);
    `CHECK("too early", 2'b01, `RV[1:0])
    rd(OFS_STATUS0);
    `CHECK("status early", {1'b1, 2'b00, wcnt}, `RV[8:0])
    rd(OFS_STATUS0);
    `CHECK("read clears", 1'b0, `RV[8])
    rd(OFS_WIN_TIMING);
    `CHECK("service timing", 32'h0000_0101, `RV)
    repeat (3000) @(posedge pclk);
    wr(OFS_WIN_SERVICE, 32'h0000_0000);
    wcnt = dec(wcnt, wd);
    rd(OFS_DIAG);
    `CHECK("open pass", 2'b00, `RV[1:0])
    rd(OFS_STATUS0);
    `CHECK("pass status", {1'b1, 2'b00, wcnt}, `RV[8:0])
    we0 = we_n;
    repeat (5000) @(posedge pclk);
    wcnt = inc(wcnt, wu);
    `CHECK("timeout pulse", 1, we_n - we0)
    rd(OFS_DIAG);
    `CHECK("timeout", 2'b10, `RV[1:0])
    rd(OFS_STATUS0);
    `CHECK("timeout status", {1'b0, 2'b00, wcnt}, `RV[8:0])
    wr(OFS_OPTION, 32'h0000_0001);
    rd(OFS_QUESTION_CODE_STAT);
    q = `RV[3:0];
    host_model_i.answer(q, 1'b0);
    rd(OFS_QUESTION_CODE_STAT);
    `CHECK("held question", q, `RV[3:0])
    monitor_halt <= 1'b1;
    we0 = we_n;
    repeat (6000) @(posedge pclk);
    `CHECK("halted", 0, we_n - we0)
    monitor_halt <= 1'b0;
    // The largest step makes the error counter stop climbing within six writes.
    wu = 4'hf;
    wr(OFS_WIN_STEP, {24'h00_0000, wd, wu});
    for (int i = 0; i < 6; i++) begin
      wr(OFS_WIN_TIMING, 32'h0000_0101);
      wcnt = inc(wcnt, wu);
    end
    rd(OFS_STATUS0);
    `CHECK("saturated", wcnt, `RV[5:0])
    $display("test window done");
    end_of_test();
  end
endmodule
`default_nettype wire
